// *** core/pfg_pkg.sv ***
// Purpose: Constants for the eight-pin port with wake-up and segment mux.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes: Offsets are register indices; a register's byte address is four times its index.

package pfg_pkg;
	localparam int PFG_WIDTH = 8;
	localparam int PFG_ADDR_W = 16;
	localparam logic [15:0] PFG_OFS_FUNC_SEL = 16'hFFCC;
	localparam logic [15:0] PFG_OFS_OUT_LATCH = 16'hFFD8;
	localparam logic [15:0] PFG_OFS_PULLUP = 16'hFFE2;
	localparam logic [15:0] PFG_OFS_DIRECTION = 16'hFFE8;
	localparam logic [15:0] PFG_OFS_CONTROL = 16'hFFF0;
	// The bus is only 16 bits wide, so the two top index bits are dropped.
	// They are the same for every register, so the addresses stay distinct.
	localparam logic [15:0] PFG_ADR_FUNC_SEL = {PFG_OFS_FUNC_SEL[13:0], 2'b00};
	localparam logic [15:0] PFG_ADR_OUT_LATCH = {PFG_OFS_OUT_LATCH[13:0], 2'b00};
	localparam logic [15:0] PFG_ADR_PULLUP = {PFG_OFS_PULLUP[13:0], 2'b00};
	localparam logic [15:0] PFG_ADR_DIRECTION = {PFG_OFS_DIRECTION[13:0], 2'b00};
	localparam logic [15:0] PFG_ADR_CONTROL = {PFG_OFS_CONTROL[13:0], 2'b00};
	localparam logic [7:0] PFG_REG_RESET = 8'h00;
	localparam logic [7:0] PFG_DIR_READ = 8'hFF;
	localparam int PFG_CTRL_STANDBY_BIT = 0;
	localparam int PFG_SEG_TOP_BIT = 3;
	localparam logic [3:0] PFG_SEG_RESET = 4'h0;
	localparam int PFG_CTRL_SEG_LSB = 4;
	localparam logic [1:0] PFG_RESP_OKAY = 2'h0;
	localparam logic [1:0] PFG_RESP_SLVERR = 2'h2;
	typedef enum logic [0:0] {
		PFG_IDLE = 1'b0,
		PFG_RESP = 1'b1
	} pfg_state_t;
endpackage

// *** core/pfg_port.sv ***
// Purpose: Eight-pin general-purpose port with wake-up and segment mux.
// Assumes: Pins are resolved outside from output, enable and pull-up.
// Notes: Each register sits at four times its index on the bus.
// Contract
// [RULE1] Data read returns latch for pins whose direction bit is one.
// [RULE2] Data read returns synchronised pin level where direction bit is zero.
// [RULE3] Direction bit one makes pin output, zero makes it input.
// [RULE4] Direction register is write-only and reads back all ones.
// [RULE5] Direction and latch act only on pins selected as general I/O; the code still gates pull-ups and the data read by direction on every pin.
// [RULE6] Pull-up on only when direction is zero and pull-up bit is one.
// [RULE7] All pull-ups are off after reset until software enables them.
// [RULE8] Function select bit zero is ordinary I/O, one is wake-up input.
// [RULE9] Segment field top bit set makes every pin a segment output.
// [RULE10] In standby pins float, except pulled-up pins which show high.
// [RULE11] Data, direction, pull-up and function select reset to zero.
// [RULE12] Pull-up and function select read back their last written value.
//
// Local design decision: the AXI4-Lite register port.

`timescale 1ns/1ps
`default_nettype none

module pfg_port
	import pfg_pkg::*;
#(
	parameter int WIDTH = PFG_WIDTH
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [WIDTH-1:0] general_io_pin_in,
	output logic [WIDTH-1:0] general_io_pin_out,
	output logic [WIDTH-1:0] general_io_pin_oe,
	output logic [WIDTH-1:0] pullup_on,
	input wire logic [WIDTH-1:0] lcd_segment_data,
	output logic [WIDTH-1:0] wakeup_input,
	output logic [3:0] segment_select_field
);

	// ************************************************************
	// Reset release and pin synchronisers
	// ************************************************************
	logic rst_meta_n;
	logic rst_sync_n;
	logic [WIDTH-1:0] pin_meta;
	logic [WIDTH-1:0] pin_sync;
	logic [WIDTH-1:0] seg_meta;
	logic [WIDTH-1:0] seg_sync;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// Pins are asynchronous, so no logic sees them before two stages.
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pin_meta <= '0;
			pin_sync <= '0;
			seg_meta <= '0;
			seg_sync <= '0;
		end else begin
			pin_meta <= general_io_pin_in;
			pin_sync <= pin_meta;
			seg_meta <= lcd_segment_data;
			seg_sync <= seg_meta;
		end
	end

	// ************************************************************
	// Register file
	// ************************************************************
	logic [WIDTH-1:0] port_output_latch;
	logic [WIDTH-1:0] port_direction;
	logic [WIDTH-1:0] port_pullup_enable;
	logic [WIDTH-1:0] port_function_select;
	logic standby;
	logic [15:0] aw_addr;
	logic [31:0] w_data;
	logic w_lane;
	logic aw_held;
	logic w_held;
	logic do_write;
	logic wr_hit;

	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_hit = (aw_addr == PFG_ADR_FUNC_SEL)
		|| (aw_addr == PFG_ADR_OUT_LATCH)
		|| (aw_addr == PFG_ADR_PULLUP)
		|| (aw_addr == PFG_ADR_DIRECTION)
		|| (aw_addr == PFG_ADR_CONTROL);

	// Address and data are taken in either order and held until both exist.
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_lane <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready;
			s_axi_wready <= !w_held && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[15:2], 2'b00};
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_lane <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= PFG_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? PFG_RESP_OKAY : PFG_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Only byte lane zero carries the eight bits; other lanes are ignored.
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			port_output_latch <= PFG_REG_RESET; // [RULE11]
			port_direction <= PFG_REG_RESET; // [RULE11]
			port_pullup_enable <= PFG_REG_RESET; // [RULE7] [RULE11]
			port_function_select <= PFG_REG_RESET; // [RULE8] [RULE11]
			segment_select_field <= PFG_SEG_RESET;
			standby <= 1'b0;
		end else if (do_write && w_lane) begin
			case (aw_addr)
				PFG_ADR_FUNC_SEL: port_function_select <= w_data[WIDTH-1:0];
				PFG_ADR_OUT_LATCH: port_output_latch <= w_data[WIDTH-1:0];
				PFG_ADR_PULLUP: port_pullup_enable <= w_data[WIDTH-1:0];
				PFG_ADR_DIRECTION: port_direction <= w_data[WIDTH-1:0];
				PFG_ADR_CONTROL: begin
					standby <= w_data[PFG_CTRL_STANDBY_BIT];
					segment_select_field <= w_data[PFG_CTRL_SEG_LSB+:4];
				end
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// Read channel
	// ************************************************************
	pfg_state_t rd_state;
	logic [WIDTH-1:0] read_port;

	// Each bit picks latch or pin by its own direction bit.
	assign read_port = (port_direction & port_output_latch)
		| (~port_direction & pin_sync); // [RULE1] [RULE2]

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rd_state <= PFG_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= PFG_RESP_OKAY;
		end else begin
			case (rd_state)
				PFG_IDLE: begin
					s_axi_arready <= !s_axi_arready;
					if (s_axi_arvalid && s_axi_arready) begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid <= 1'b1;
						s_axi_rresp <= PFG_RESP_OKAY;
						s_axi_rdata <= '0;
						rd_state <= PFG_RESP;
						case ({s_axi_araddr[15:2], 2'b00})
							PFG_ADR_FUNC_SEL:
								s_axi_rdata[WIDTH-1:0] <= port_function_select; // [RULE12]
							PFG_ADR_OUT_LATCH:
								s_axi_rdata[WIDTH-1:0] <= read_port;
							PFG_ADR_PULLUP:
								s_axi_rdata[WIDTH-1:0] <= port_pullup_enable; // [RULE12]
							PFG_ADR_DIRECTION:
								s_axi_rdata[WIDTH-1:0] <= PFG_DIR_READ; // [RULE4]
							PFG_ADR_CONTROL: begin
								s_axi_rdata[PFG_CTRL_STANDBY_BIT] <= standby;
								s_axi_rdata[PFG_CTRL_SEG_LSB+:4] <= segment_select_field;
							end
							default: s_axi_rresp <= PFG_RESP_SLVERR;
						endcase
					end
				end
				PFG_RESP: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rd_state <= PFG_IDLE;
					end
				end
				default: rd_state <= PFG_IDLE;
			endcase
		end
	end

	// ************************************************************
	// Pin function mux
	// ************************************************************
	logic seg_mode;
	logic [WIDTH-1:0] next_oe;
	logic [WIDTH-1:0] next_out;
	logic [WIDTH-1:0] next_pull;
	logic [WIDTH-1:0] next_wake;

	assign seg_mode = segment_select_field[PFG_SEG_TOP_BIT];

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_pin
			logic gpio_sel;
			assign gpio_sel = !seg_mode && !port_function_select[gi]; // [RULE5] [RULE8]
			always_comb begin
				next_pull[gi] = !port_direction[gi]
					&& port_pullup_enable[gi]; // [RULE6]
				next_wake[gi] = !seg_mode && port_function_select[gi]; // [RULE8]
				if (standby) begin
					next_oe[gi] = 1'b0; // [RULE10]
					next_out[gi] = 1'b0;
				end else if (seg_mode) begin
					next_oe[gi] = 1'b1; // [RULE9]
					next_out[gi] = seg_sync[gi];
				end else if (gpio_sel) begin
					next_oe[gi] = port_direction[gi]; // [RULE3] [RULE5]
					next_out[gi] = port_output_latch[gi];
				end else begin
					next_oe[gi] = 1'b0;
					next_out[gi] = 1'b0;
				end
			end
		end
	endgenerate

	// Wake-up is passed as the synchronised pin level; edge logic is outside.
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			general_io_pin_oe <= '0;
			general_io_pin_out <= '0;
			pullup_on <= '0; // [RULE7]
			wakeup_input <= '0;
		end else begin
			general_io_pin_oe <= next_oe;
			general_io_pin_out <= next_out;
			pullup_on <= next_pull; // [RULE6] [RULE10]
			wakeup_input <= next_wake & pin_sync;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	dir_readback_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(s_axi_arvalid && s_axi_arready
		&& {s_axi_araddr[15:2], 2'b00} == PFG_ADR_DIRECTION)
		|=> s_axi_rdata[7:0] == 8'hFF) // [RULE4]
		else $error("direction read not all ones");

	data_read_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(s_axi_arvalid && s_axi_arready
		&& {s_axi_araddr[15:2], 2'b00} == PFG_ADR_OUT_LATCH)
		|=> s_axi_rdata[WIDTH-1:0] == $past(read_port)) // [RULE1] [RULE2]
		else $error("data read mismatch");

	pull_gate_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		pullup_on == ($past(port_pullup_enable) & ~$past(port_direction))) // [RULE6]
		else $error("pull-up gating wrong");

	seg_drive_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		($past(seg_mode) && !$past(standby)) |-> general_io_pin_oe == '1) // [RULE9]
		else $error("segment mode not driving");

	standby_float_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		$past(standby) |-> general_io_pin_oe == '0) // [RULE10]
		else $error("pins driven in standby");

	wake_no_drive_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(!$past(seg_mode)) |->
		(general_io_pin_oe & $past(port_function_select)) == '0) // [RULE5]
		else $error("wake-up pin driven");

	gpio_dir_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(!$past(seg_mode) && !$past(standby)) |->
		general_io_pin_oe == ($past(port_direction)
		& ~$past(port_function_select))) // [RULE3]
		else $error("direction not applied");

	reset_clear_a: assert property (@(posedge mclk)
		!rst_sync_n |-> (port_output_latch == 8'h00
		&& port_direction == 8'h00 && port_pullup_enable == 8'h00
		&& port_function_select == 8'h00)) // [RULE11]
		else $error("registers not cleared");

	pull_write_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(do_write && w_lane && aw_addr == PFG_ADR_PULLUP)
		|=> port_pullup_enable == $past(w_data[WIDTH-1:0])) // [RULE12]
		else $error("pull-up write lost");

endmodule // pfg_port

`default_nettype wire

// *** sim/pfg_pin_model.sv ***
// Purpose: External circuitry on the eight port pins.
// Assumes: Where the bench and the port both drive a pin, as in t_wake before the select write, the port's level wins.
// Notes: An undriven pin without pull-up shows a pattern that changes each cycle.

`timescale 1ns/1ps
`default_nettype none

module pfg_pin_model
	import pfg_pkg::*;
(
	input wire logic mclk,
	input wire logic [PFG_WIDTH-1:0] pin_out,
	input wire logic [PFG_WIDTH-1:0] pin_oe,
	input wire logic [PFG_WIDTH-1:0] pull_on,
	input wire logic [PFG_WIDTH-1:0] ext_val,
	input wire logic [PFG_WIDTH-1:0] ext_en,
	output logic [PFG_WIDTH-1:0] pin_level
);
	logic [PFG_WIDTH-1:0] churn = '0;
	always @(posedge mclk) begin
		churn <= ~churn;
	end
	// A floating pin must not look like a settled level, or reads pass by luck.
	always_comb begin
		for (int i = 0; i < PFG_WIDTH; i++) begin
			if (pin_oe[i])
				pin_level[i] = pin_out[i];
			else if (ext_en[i])
				pin_level[i] = ext_val[i];
			else if (pull_on[i])
				pin_level[i] = 1'b1;
			else
				pin_level[i] = churn[i];
		end
	end
endmodule // pfg_pin_model

`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the port with wake-up and segment mux.
// Assumes: Printed offsets are register indices, byte address four times.
// Notes: The control register is indexed like the port registers.

`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import pfg_pkg::*;
	logic mclk, rst_n;
	logic [15:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, seg;
	logic [1:0] bresp, rresp;
	logic [7:0] pin_in, pin_out, pin_oe, pull, lcd, wake, ext_val, ext_en;
	int err_count, num_checks, cycles;

	pfg_port i_pfg_port (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .general_io_pin_in(pin_in),
		.general_io_pin_out(pin_out), .general_io_pin_oe(pin_oe),
		.pullup_on(pull), .lcd_segment_data(lcd), .wakeup_input(wake),
		.segment_select_field(seg));
	pfg_pin_model i_pfg_pin_model (.mclk(mclk), .pin_out(pin_out),
		.pin_oe(pin_oe), .pull_on(pull), .ext_val(ext_val), .ext_en(ext_en),
		.pin_level(pin_in));

	// ****************************************
	// Clock, reset and hang guard
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_count++;
			wrap_up();
		end
	end

	function automatic logic [15:0] ra(input logic [15:0] idx);
		return {idx[13:0], 2'b00};
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// ****************************************
	// Register bus master
	// ****************************************
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic aw, w;
		@(posedge mclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w) begin
			@(posedge mclk);
			if (aw && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw = 1'b0;
			end
			if (w && wready === 1'b1) begin
				wvalid <= 1'b0;
				w = 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge mclk);
		bready <= 1'b0;
		chk(bresp, PFG_RESP_OKAY, "write response");
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] exp,
		input logic [1:0] er, input string msg);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge mclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, exp, msg);
		chk(rresp, er, "read response");
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rd(ra(PFG_OFS_FUNC_SEL), 0, PFG_RESP_OKAY, "func sel reset");
		rd(ra(PFG_OFS_PULLUP), 0, PFG_RESP_OKAY, "pull-up reset");
		rd(ra(PFG_OFS_DIRECTION), 32'hFF, PFG_RESP_OKAY, "dir read");
		chk(pull, 0, "pull-ups after reset");
		chk(pin_oe, 0, "all inputs after reset");
		$display("test reset done");
	endtask

	task automatic t_dir();
		wr(ra(PFG_OFS_OUT_LATCH), 8'hA5);
		wr(ra(PFG_OFS_DIRECTION), 8'h0F);
		rd(ra(PFG_OFS_DIRECTION), 32'hFF, PFG_RESP_OKAY, "dir wo");
		chk(pin_oe, 8'h0F, "direction drive");
		chk(pin_out[3:0], 4'h5, "latch on outputs");
		rd(ra(PFG_OFS_OUT_LATCH), 32'h35, PFG_RESP_OKAY, "mixed read");
		$display("test direction done");
	endtask

	task automatic t_pull();
		wr(ra(PFG_OFS_PULLUP), 8'hFF);
		repeat (2) @(posedge mclk);
		chk(pull, 8'hF0, "pull-up only on inputs");
		rd(ra(PFG_OFS_PULLUP), 32'hFF, PFG_RESP_OKAY, "pull-up back");
		ext_en <= 8'h00;
		repeat (4) @(posedge mclk);
		rd(ra(PFG_OFS_OUT_LATCH), 32'hF5, PFG_RESP_OKAY, "pulled pins");
		$display("test pull-up done");
	endtask

	task automatic t_wake();
		ext_val <= 8'h0A;
		ext_en <= 8'h0F;
		wr(ra(PFG_OFS_FUNC_SEL), 8'h0F);
		repeat (4) @(posedge mclk);
		chk(pin_oe, 8'h00, "wake-up pins released");
		chk(wake, 8'h0A, "wake-up inputs");
		rd(ra(PFG_OFS_FUNC_SEL), 32'h0F, PFG_RESP_OKAY, "sel back");
		ext_en <= 8'h00;
		wr(ra(PFG_OFS_FUNC_SEL), 8'h00);
		$display("test wake-up done");
	endtask

	task automatic t_seg_stby();
		wr(ra(PFG_OFS_CONTROL), 8'h80);
		repeat (4) @(posedge mclk);
		chk(seg, 4'h8, "segment field");
		chk(pin_oe, 8'hFF, "segment drive");
		chk(pin_out, 8'hC3, "segment data");
		rd(ra(PFG_OFS_CONTROL), 32'h80, PFG_RESP_OKAY, "control back");
		wr(ra(PFG_OFS_CONTROL), 8'h01);
		repeat (2) @(posedge mclk);
		chk(pin_oe, 8'h00, "standby float");
		chk(pull, 8'hF0, "standby pull-up");
		rd(ra(PFG_OFS_CONTROL), 32'h01, PFG_RESP_OKAY, "standby back");
		wr(ra(PFG_OFS_CONTROL), 8'h00);
		rd(16'h0000, 0, PFG_RESP_SLVERR, "unmapped");
		$display("test segment standby done");
	endtask

	initial begin
		rst_n = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		lcd = 8'hC3;
		ext_val = 8'h3C;
		ext_en = 8'hF0;
		err_count = 0;
		num_checks = 0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_dir();
		t_pull();
		t_wake();
		t_seg_stby();
		wrap_up();
	end
endmodule // tb_top

`default_nettype wire
